// ===== design/pmtc_pkg.sv
// Package with constants for the packet modem task control block
package pmtc_pkg;
   // Host register addresses (two address inputs)
   localparam logic [1:0] ADDR_DATA    = 2'h0;
   localparam logic [1:0] ADDR_COMMAND = 2'h1;
   localparam logic [1:0] ADDR_MODE    = 2'h2;
   localparam logic [1:0] ADDR_CONTROL = 2'h3;
   // Command byte fields
   localparam int CMD_SYMBOL_BIT = 7;
   localparam int CMD_LEVEL_BIT  = 6;
   localparam int CMD_TASK_MSB   = 2;
   // Mode register fields
   localparam int MODE_TX_BIT    = 7;
   localparam int MODE_INTERRUPT_OUTPUT_ENABLE_BIT = 6;
   // Status register fields
   localparam int STAT_IRQ_BIT    = 7;
   localparam int STAT_VACANT_BIT = 6;
   // Task codes
   localparam logic [2:0] TASK_NOP    = 3'h0;
   localparam logic [2:0] TASK_CODE1  = 3'h1;
   localparam logic [2:0] TASK_CODE2  = 3'h2;
   localparam logic [2:0] TASK_CODE3  = 3'h3;
   localparam logic [2:0] TASK_CODE4  = 3'h4;
   localparam logic [2:0] TASK_CODE5  = 3'h5;
   localparam logic [2:0] TASK_NOP2   = 3'h6;
   localparam logic [2:0] TASK_CANCEL = 3'h7;
   // Buffer
   localparam int          BUF_BYTES = 12;
   localparam logic [3:0]  BUF_LAST  = 4'hB;
   // Symbol levels, signed 4-bit filter input code
   localparam logic [3:0]  LEVEL_MID = 4'h0;
   // Acquisition sequence lengths in steps
   localparam logic [2:0]  ACQ_STEPS = 3'h7;
   // Reset values
   localparam logic [7:0]  MODE_RESET    = 8'h00;
   localparam logic [7:0]  CONTROL_RESET = 8'h00;
   // Task state machine states, one-hot
   typedef enum logic [3:0]
   {
      ST_IDLE = 4'b0001,
      ST_LOAD = 4'b0010,
      ST_WAIT = 4'b0100,
      ST_FILL = 4'b1000
   } pmtc_state_t;
endpackage

// ===== design/pmtc_acq_seq.sv
// Acquisition sequencer: widest setting first, steps down to normal
`timescale 1ns/1ps
module pmtc_acq_seq
(
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       rst,
   // Control
   input  wire logic       restart,
   input  wire logic       step,
   input  wire logic [1:0] normal_setting,
   // Result
   output logic [2:0]      setting,
   output logic            busy
);
   logic [2:0] count_q;

   // Restart always wins so every request begins from the start
   always_ff @(posedge mclk)
   begin
      if (rst)
         count_q <= 3'h0;
      else if (restart)
         count_q <= pmtc_pkg::ACQ_STEPS;
      else if (step && count_q != 3'h0)
         count_q <= count_q - 3'h1;
   end

   // Setting never narrows below the configured normal value
   assign busy    = (count_q != 3'h0);
   assign setting = (count_q > {1'b0, normal_setting}) ? count_q : {1'b0, normal_setting};
endmodule

// ===== design/pmtc_buffer.sv
// Twelve byte block buffer, flip-flop storage addressed by index
`timescale 1ns/1ps
module pmtc_buffer
(
   // Clock
   input  wire logic       mclk,
   // Write port
   input  wire logic       wr_en,
   input  wire logic [3:0] wr_idx,
   input  wire logic [7:0] wr_data,
   // Read port
   input  wire logic [3:0] rd_idx,
   output logic [7:0]      rd_data
);
   logic [7:0] mem_q [pmtc_pkg::BUF_BYTES];

   // One generate entry per byte
   for (genvar i = 0; i < pmtc_pkg::BUF_BYTES; i++)
   begin : g_byte
      always_ff @(posedge mclk)
      begin
         if (wr_en && wr_idx == 4'(i))
            mem_q[i] <= wr_data;
      end
   end

   // Out-of-range index reads zero
   assign rd_data = (rd_idx <= pmtc_pkg::BUF_LAST) ? mem_q[rd_idx] : 8'h00;
endmodule

// ===== design/pmtc_top.sv
// Task dispatch and block buffer control of a four-level FSK packet modem
`timescale 1ns/1ps
module pmtc_top
(
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       rst,
   // Host bus
   input  wire logic       cs_n,
   input  wire logic       wr_n,
   input  wire logic       rd_n,
   input  wire logic [1:0] addr,
   input  wire logic [7:0] data_in,
   output logic [7:0]      data_out,
   output logic            data_oe_n,
   output logic            irq_n,
   // Interleave store (transmit)
   output logic [7:0]      ilv_data,
   output logic            ilv_valid,
   input  wire logic       ilv_ready,
   input  wire logic       tx_busy,
   // De-interleave store (receive)
   input  wire logic       dil_enough,
   input  wire logic [7:0] dil_data,
   input  wire logic       dil_valid,
   output logic            dil_take,
   output logic            dil_shift_en,
   input  wire logic [7:0] quality,
   // Datapath controls
   output logic [2:0]      task_code,
   output logic            task_start,
   output logic            task_abort,
   output logic [3:0]      tx_filter_level,
   output logic            tx_filter_override,
   output logic            quality_enable,
   output logic [2:0]      timing_loop_bandwidth,
   output logic            acquire_symbol_timing,
   output logic [2:0]      level_response_time,
   output logic            acquire_signal_levels,
   input  wire logic       symbol_tick
);
   ////////////////////////////////////////////////////////////////////////////
   // Host access decode
   logic       host_wr;
   logic       host_rd;
   logic       rd_q;
   logic [7:0] mode_q;
   logic [7:0] control_q;
   logic       tx_dir;
   logic       buffer_vacant_q;
   logic       irq_flag_q;
   logic [3:0] ptr_q;
   logic [3:0] eng_idx_q;
   logic [2:0] task_q;
   pmtc_pkg::pmtc_state_t state_q;
   logic       cmd_wr;
   logic [2:0] cmd_task;
   logic       cancel;
   logic       buf_wr_host;
   logic       buf_rd_host;
   logic       buf_wr;
   logic [3:0] buf_wr_idx;
   logic [7:0] buf_wr_data;
   logic [3:0] buf_rd_idx;
   logic [7:0] buf_rd_data;
   logic [7:0] status;

   // Strobes are sampled as levels on mclk, so a write counts once per low
   // cycle and the host must hold each write for exactly one cycle
   // Reads act once per strobe, on its leading edge
   assign host_wr = !cs_n && !wr_n;
   assign host_rd = !cs_n && !rd_n;
   assign tx_dir  = mode_q[pmtc_pkg::MODE_TX_BIT];

   always_ff @(posedge mclk)
   begin
      if (rst)
         rd_q <= 1'b0;
      else
         rd_q <= host_rd;
   end

   assign cmd_wr      = host_wr && addr == pmtc_pkg::ADDR_COMMAND;
   assign cmd_task    = data_in[pmtc_pkg::CMD_TASK_MSB:0];
   assign cancel      = cmd_wr && cmd_task == pmtc_pkg::TASK_CANCEL;
   assign buf_wr_host = host_wr && addr == pmtc_pkg::ADDR_DATA && !tx_dir ? 1'b0
                      : host_wr && addr == pmtc_pkg::ADDR_DATA;
   assign buf_rd_host = host_rd && !rd_q && addr == pmtc_pkg::ADDR_DATA && !tx_dir;

   ////////////////////////////////////////////////////////////////////////////
   // Write-only mode and control registers
   // Neither reads back; those addresses return quality or zero instead
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         mode_q    <= pmtc_pkg::MODE_RESET;
         control_q <= pmtc_pkg::CONTROL_RESET;
      end
      else if (host_wr && addr == pmtc_pkg::ADDR_MODE)
         mode_q <= data_in;
      else if (host_wr && addr == pmtc_pkg::ADDR_CONTROL)
         control_q <= data_in;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Buffer position pointer, one step per host buffer write in transmit or buffer read in receive
   // Saturating at the last byte keeps an over-long burst off byte 0
   always_ff @(posedge mclk)
   begin
      if (rst || cancel)
         ptr_q <= 4'h0;
      else if (cmd_wr && cmd_task != pmtc_pkg::TASK_NOP)
         ptr_q <= 4'h0;
      else if ((buf_wr_host || buf_rd_host) && ptr_q != pmtc_pkg::BUF_LAST)
         ptr_q <= ptr_q + 4'h1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Task acceptance
   // Only an idle block takes a task; cancel has its own path so that it
   // works in any state and is never reported as a started task
   logic task_accept;
   assign task_accept = cmd_wr
                     && state_q == pmtc_pkg::ST_IDLE
                     && cmd_task != pmtc_pkg::TASK_NOP
                     && cmd_task != pmtc_pkg::TASK_NOP2
                     && cmd_task != pmtc_pkg::TASK_CANCEL;

   ////////////////////////////////////////////////////////////////////////////
   // Task state machine
   // A task written while another runs is dropped: the host waits for the
   // vacant flag, so nothing is queued here
   // Host writes go to the pointer; engine fills by its own index
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         state_q   <= pmtc_pkg::ST_IDLE;
         task_q    <= pmtc_pkg::TASK_NOP;
         eng_idx_q <= 4'h0;
      end
      else if (cancel)
      begin
         state_q   <= pmtc_pkg::ST_IDLE;
         task_q    <= pmtc_pkg::TASK_NOP;
         eng_idx_q <= 4'h0;
      end
      else
      begin
         case (state_q)
            pmtc_pkg::ST_IDLE:
            begin
               if (cmd_wr && cmd_task != pmtc_pkg::TASK_NOP
                   && cmd_task != pmtc_pkg::TASK_NOP2)
               begin
                  task_q    <= cmd_task;
                  eng_idx_q <= 4'h0;
                  state_q   <= tx_dir ? pmtc_pkg::ST_LOAD : pmtc_pkg::ST_WAIT;
               end
            end
            pmtc_pkg::ST_LOAD:
            begin
               // Stalls on ilv_ready when the store is still full
               if (ilv_ready)
               begin
                  if (eng_idx_q == pmtc_pkg::BUF_LAST)
                     state_q <= pmtc_pkg::ST_IDLE;
                  else
                     eng_idx_q <= eng_idx_q + 4'h1;
               end
            end
            pmtc_pkg::ST_WAIT:
            begin
               if (dil_enough)
                  state_q <= pmtc_pkg::ST_FILL;
            end
            pmtc_pkg::ST_FILL:
            begin
               // Receive always fills all twelve bytes before flagging
               if (dil_valid)
               begin
                  if (eng_idx_q == pmtc_pkg::BUF_LAST)
                     state_q <= pmtc_pkg::ST_IDLE;
                  else
                     eng_idx_q <= eng_idx_q + 4'h1;
               end
            end
            default:
               state_q <= pmtc_pkg::ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Buffer vacant and interrupt flags
   // Completion is the cycle in which the last byte moves
   logic task_done;
   assign task_done = (state_q == pmtc_pkg::ST_LOAD && ilv_ready
                       && eng_idx_q == pmtc_pkg::BUF_LAST)
                   || (state_q == pmtc_pkg::ST_FILL && dil_valid
                       && eng_idx_q == pmtc_pkg::BUF_LAST);

   // Completion and cancel set vacant ahead of a task write clearing it
   always_ff @(posedge mclk)
   begin
      if (rst)
         buffer_vacant_q <= 1'b1;
      else if (task_done || cancel)
         buffer_vacant_q <= 1'b1;
      else if (task_accept)
         buffer_vacant_q <= 1'b0;
   end

   // Interrupt flag clears on a status read; a set in the same cycle wins
   always_ff @(posedge mclk)
   begin
      if (rst)
         irq_flag_q <= 1'b0;
      else if (task_done)
         irq_flag_q <= 1'b1;
      else if (host_rd && !rd_q && addr == pmtc_pkg::ADDR_COMMAND)
         irq_flag_q <= 1'b0;
   end

   assign irq_n = !(irq_flag_q && mode_q[pmtc_pkg::MODE_INTERRUPT_OUTPUT_ENABLE_BIT]);

   ////////////////////////////////////////////////////////////////////////////
   // Block buffer
   // Host and engine share one write port; the engine writes only while
   // filling, and receive refuses host writes, so the two never collide
   assign buf_wr      = buf_wr_host || (state_q == pmtc_pkg::ST_FILL && dil_valid);
   assign buf_wr_idx  = (state_q == pmtc_pkg::ST_FILL) ? eng_idx_q : ptr_q;
   assign buf_wr_data = (state_q == pmtc_pkg::ST_FILL) ? dil_data : data_in;
   assign buf_rd_idx  = (state_q == pmtc_pkg::ST_LOAD) ? eng_idx_q : ptr_q;

   pmtc_buffer u_buffer
   (
      .mclk    (mclk),
      .wr_en   (buf_wr),
      .wr_idx  (buf_wr_idx),
      .wr_data (buf_wr_data),
      .rd_idx  (buf_rd_idx),
      .rd_data (buf_rd_data)
   );

   assign ilv_data  = buf_rd_data;
   assign ilv_valid = (state_q == pmtc_pkg::ST_LOAD);
   assign dil_take  = (state_q == pmtc_pkg::ST_FILL);

   ////////////////////////////////////////////////////////////////////////////
   // Read data, registered so the bus sees one steady byte per strobe
   // Status byte: interrupt and vacant flags, the rest reads as zero here
   always_comb
   begin
      status = 8'h00;
      status[pmtc_pkg::STAT_IRQ_BIT]    = irq_flag_q;
      status[pmtc_pkg::STAT_VACANT_BIT] = buffer_vacant_q;
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
         data_out <= 8'h00;
      else if (host_rd && !rd_q)
      begin
         case (addr)
            pmtc_pkg::ADDR_DATA:    data_out <= tx_dir ? 8'h00 : buf_rd_data;
            pmtc_pkg::ADDR_COMMAND: data_out <= status;
            pmtc_pkg::ADDR_MODE:    data_out <= quality;
            default:                data_out <= 8'h00;
         endcase
      end
   end

   assign data_oe_n = !host_rd;

   ////////////////////////////////////////////////////////////////////////////
   // Datapath task outputs
   assign task_code  = task_q;
   assign task_start = task_accept;
   assign task_abort = cancel;

   // Idle behaviour per direction
   // The filter hold lets go as soon as the transmitter reports it is busy
   assign tx_filter_override = tx_dir && state_q == pmtc_pkg::ST_IDLE && !tx_busy;
   assign tx_filter_level    = pmtc_pkg::LEVEL_MID;
   assign quality_enable     = !tx_dir;
   assign dil_shift_en       = !tx_dir;

   ////////////////////////////////////////////////////////////////////////////
   // Acquisition sequencers, receive only
   // Both share the symbol tick; a restart mid-sequence starts from the widest
   logic aq_sym_restart;
   logic aq_lev_restart;
   assign aq_sym_restart = cmd_wr && !tx_dir && data_in[pmtc_pkg::CMD_SYMBOL_BIT];
   assign aq_lev_restart = cmd_wr && !tx_dir && data_in[pmtc_pkg::CMD_LEVEL_BIT];

   pmtc_acq_seq u_sym_acq
   (
      .mclk           (mclk),
      .rst            (rst),
      .restart        (aq_sym_restart),
      .step           (symbol_tick),
      .normal_setting (control_q[1:0]),
      .setting        (timing_loop_bandwidth),
      .busy           (acquire_symbol_timing)
   );

   pmtc_acq_seq u_lev_acq
   (
      .mclk           (mclk),
      .rst            (rst),
      .restart        (aq_lev_restart),
      .step           (symbol_tick),
      .normal_setting (control_q[3:2]),
      .setting        (level_response_time),
      .busy           (acquire_signal_levels)
   );
endmodule

// ===== verification/pmtc_top_props.sv
// Assertion checker for the packet modem task control block
`timescale 1ns/1ps
module pmtc_top_props
(
   // Clock and reset
   input wire logic       mclk,
   input wire logic       rst,
   // Host bus
   input wire logic       cs_n,
   input wire logic       wr_n,
   input wire logic       rd_n,
   input wire logic [1:0] addr,
   input wire logic [7:0] data_in,
   input wire logic [7:0] data_out,
   input wire logic       data_oe_n,
   input wire logic       irq_n,
   // Datapath side
   input wire logic       task_start,
   input wire logic       task_abort,
   input wire logic [2:0] task_code,
   input wire logic [3:0] tx_filter_level,
   input wire logic       tx_filter_override,
   input wire logic       dil_shift_en,
   input wire logic       acquire_symbol_timing,
   input wire logic       acquire_signal_levels
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   logic       cmd_wr;
   logic       rd_act;
   logic       rd_q;
   logic       tx_q;
   logic       ien_q;
   logic [2:0] wr_code;
   // Decoded host bus events
   assign cmd_wr  = !cs_n && !wr_n && addr == pmtc_pkg::ADDR_COMMAND;
   assign rd_act  = !cs_n && !rd_n;
   assign wr_code = data_in[pmtc_pkg::CMD_TASK_MSB:0];
   ////////////////////////////////////////////////////////////
   // Shadow of the mode bits, write-only so ports cannot show them
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         tx_q  <= 1'b0;
         ien_q <= 1'b0;
      end
      else if (!cs_n && !wr_n && addr == pmtc_pkg::ADDR_MODE)
      begin
         tx_q  <= data_in[pmtc_pkg::MODE_TX_BIT];
         ien_q <= data_in[pmtc_pkg::MODE_INTERRUPT_OUTPUT_ENABLE_BIT];
      end
   end
   // Only the first cycle of a read acts
   always_ff @(posedge mclk)
   begin
      rd_q <= rd_act;
   end
   ////////////////////////////////////////////////////////////
   chk_oe_follow: assert property (data_oe_n != rd_act)
      else $error("bus enable not tied to read strobe");
   chk_irq_masked: assert property (!ien_q |-> irq_n)
      else $error("interrupt pin low while disabled");
   chk_read_ignored: assert property (tx_q && rd_act && !rd_q && addr == 2'h0 |=> data_out == 8'h00)
      else $error("buffer read answered in transmit");
   chk_timing_acq: assert property (!tx_q && cmd_wr && data_in[7] |-> ##[1:2] acquire_symbol_timing)
      else $error("timing acquisition not started");
   chk_level_acq: assert property (!tx_q && cmd_wr && data_in[6] |-> ##[1:2] acquire_signal_levels)
      else $error("level acquisition not started");
   chk_start_cause: assert property (task_start |-> cmd_wr && wr_code != 3'h0
      && wr_code != 3'h6 && wr_code != 3'h7 ##1 task_code == $past(wr_code))
      else $error("task start without a task write");
   chk_nop_quiet: assert property (cmd_wr && (wr_code == 3'h0 || wr_code == 3'h6)
      |-> !task_start && !task_abort)
      else $error("no-operation code started something");
   chk_cancel_abort: assert property (cmd_wr && wr_code == 3'h7 |-> task_abort && !task_start)
      else $error("cancel code did not abort");
   chk_filter_mid: assert property (tx_filter_override |-> tx_filter_level == 4'h0)
      else $error("idle filter level not midway");
   chk_rx_shift: assert property (!tx_q |-> dil_shift_en)
      else $error("receive shifting stopped");
   cov_start: cover property (task_start);
   cov_abort: cover property (task_abort);
   cov_irq: cover property (!irq_n);
endmodule
bind pmtc_top pmtc_top_props u_props (.mclk(mclk), .rst(rst), .cs_n(cs_n), .wr_n(wr_n),
   .rd_n(rd_n), .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
   .irq_n(irq_n), .task_start(task_start), .task_abort(task_abort), .task_code(task_code),
   .tx_filter_level(tx_filter_level), .tx_filter_override(tx_filter_override),
   .dil_shift_en(dil_shift_en), .acquire_symbol_timing(acquire_symbol_timing),
   .acquire_signal_levels(acquire_signal_levels));

// ===== verification/pmtc_host_model.sv
// Host controller model driving the modem register bus
`timescale 1ns/1ps
module pmtc_host_model
(
   // Clock
   input wire logic       mclk,
   // Register bus
   output logic           cs_n,
   output logic           wr_n,
   output logic           rd_n,
   output logic [1:0]     addr,
   output logic [7:0]     data_in,
   input wire logic [7:0] data_out
);
   // Bus idle from time zero
   initial
   begin
      cs_n    = 1'b1;
      wr_n    = 1'b1;
      rd_n    = 1'b1;
      addr    = 2'h0;
      data_in = 8'h00;
   end
   // One write held for a single edge, since every low cycle counts
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge mclk);
      cs_n    <= 1'b0;
      wr_n    <= 1'b0;
      addr    <= a;
      data_in <= d;
      @(posedge mclk);
      cs_n    <= 1'b1;
      wr_n    <= 1'b1;
      data_in <= ~d;
   endtask
   // One read, data taken an edge after the strobe is first seen
   task automatic rd(input logic [1:0] a, output logic [7:0] d);
      @(posedge mclk);
      cs_n <= 1'b0;
      rd_n <= 1'b0;
      addr <= a;
      @(posedge mclk);
      @(posedge mclk);
      d = data_out;
      cs_n <= 1'b1;
      rd_n <= 1'b1;
   endtask
endmodule

// ===== verification/tb_packet_modem_task_control.sv
// Self-checking bench for the packet modem task control block
`timescale 1ns/1ps
module tb_packet_modem_task_control;
   logic        mclk = 1'b0, rst = 1'b1, ilv_ready = 1'b1, dil_enough = 1'b0, dil_valid = 1'b0;
   logic        cs_n, wr_n, rd_n, data_oe_n, irq_n, ilv_valid, dil_take, task_start, task_abort;
   logic        acquire_symbol_timing, acquire_signal_levels, quality_enable, symbol_tick = 1'b0;
   logic [2:0]  bw, lrt;
   logic [1:0]  addr;
   logic [7:0]  data_in, data_out, ilv_data, d, dil_data = 8'h30;
   logic [7:0]  got [12];
   int          err_count = 0, samples_checked = 0, n_start = 0, n_abort = 0, n_tx = 0;
   int          rx_n = 0, s0, a0;
   // Rows: direction, command, then start, abort and two acquisition flags
   logic [15:0] rows [19] = '{16'h1018, 16'h1028, 16'h1038, 16'h1048, 16'h1058, 16'h1060,
      16'h1C74, 16'h0000, 16'h0018, 16'h0028, 16'h0038, 16'h0048, 16'h0058, 16'h0060,
      16'h0380, 16'h03A8, 16'h0074, 16'h0802, 16'h0403};
   always #20 mclk = ~mclk;
   pmtc_host_model u_host (.mclk(mclk), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .addr(addr),
      .data_in(data_in), .data_out(data_out));
   pmtc_top DUT (.mclk(mclk), .rst(rst), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .addr(addr),
      .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n), .irq_n(irq_n),
      .ilv_data(ilv_data), .ilv_valid(ilv_valid), .ilv_ready(ilv_ready), .tx_busy(1'b0),
      .dil_enough(dil_enough), .dil_data(dil_data), .dil_valid(dil_valid), .dil_take(dil_take),
      .dil_shift_en(), .quality(8'h5A), .task_code(), .task_start(task_start),
      .task_abort(task_abort), .tx_filter_level(), .tx_filter_override(),
      .quality_enable(quality_enable), .timing_loop_bandwidth(bw),
      .acquire_symbol_timing(acquire_symbol_timing), .level_response_time(lrt),
      .acquire_signal_levels(acquire_signal_levels), .symbol_tick(symbol_tick));
   ////////////////////////////////////////////////////////////
   // Pulse counters, interleave sink and de-interleave byte source
   always @(posedge mclk)
   begin
      if (task_start === 1'b1) n_start++;
      if (task_abort === 1'b1) n_abort++;
      if (ilv_valid === 1'b1 && ilv_ready === 1'b1 && n_tx < 12)
      begin
         got[n_tx] = ilv_data;
         n_tx++;
      end
      if (dil_valid) rx_n++;
      dil_valid <= dil_enough && dil_take === 1'b1 && rx_n < 12;
      dil_data  <= 8'(8'h30 + rx_n);
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         err_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Bounded wait for the interrupt pin
   task automatic wait_irq;
      for (int i = 0; i < 300 && irq_n !== 1'b0; i++) @(posedge mclk);
      check({7'h0, irq_n}, 8'h00);
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   // Main sequence; a cancel after each row brings the block back to idle
   initial
   begin
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      check(data_out, 8'h00);
      foreach (rows[i])
      begin
         u_host.wr(2'h2, {rows[i][12], 7'h00});
         s0 = n_start;
         a0 = n_abort;
         u_host.wr(2'h1, rows[i][11:4]);
         repeat (3) @(posedge mclk);
         check(8'(n_start - s0), {7'h0, rows[i][3]});
         check(8'(n_abort - a0), {7'h0, rows[i][2]});
         check({6'h0, acquire_symbol_timing, acquire_signal_levels}, {6'h0, rows[i][1:0]});
         u_host.wr(2'h1, 8'h07);
      end
      $display("test table done");
      rst <= 1'b1;
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      u_host.rd(2'h1, d);
      check({6'h0, d[7:6]}, 8'h01);
      $display("test reset done");
      u_host.wr(2'h2, 8'hC0);
      u_host.rd(2'h0, d);
      check(d, 8'h00);
      ilv_ready <= 1'b0;
      for (int i = 0; i < 12; i++) u_host.wr(2'h0, 8'(i * 17 + 1));
      u_host.wr(2'h1, 8'h03);
      n_tx = 0;
      u_host.rd(2'h1, d);
      check({6'h0, d[7:6]}, 8'h00);
      check({7'h0, ilv_valid}, 8'h01);
      ilv_ready <= 1'b1;
      wait_irq();
      for (int i = 0; i < 12; i++) check(got[i], 8'(i * 17 + 1));
      u_host.rd(2'h1, d);
      check({6'h0, d[7:6]}, 8'h03);
      check({7'h0, irq_n}, 8'h01);
      $display("test transmit done");
      u_host.wr(2'h2, 8'h40);
      rx_n = 0;
      u_host.wr(2'h1, 8'h03);
      u_host.rd(2'h1, d);
      check({6'h0, d[7:6]}, 8'h00);
      dil_enough <= 1'b1;
      wait_irq();
      dil_enough <= 1'b0;
      u_host.wr(2'h0, 8'hAA);
      for (int i = 0; i < 12; i++)
      begin
         u_host.rd(2'h0, d);
         check(d, 8'(8'h30 + i));
      end
      $display("test receive done");
      u_host.wr(2'h1, 8'hC1);
      u_host.rd(2'h1, d);
      check({7'h0, d[6]}, 8'h00);
      a0 = n_abort;
      u_host.wr(2'h1, 8'h07);
      u_host.rd(2'h1, d);
      check({7'h0, d[6]}, 8'h01);
      check(8'(n_abort - a0), 8'h01);
      u_host.rd(2'h0, d);
      check(d, 8'h30);
      $display("test cancel done");
      check({7'h0, quality_enable}, 8'h01);
      u_host.rd(2'h2, d);
      check(d, 8'h5A);
      check({5'h0, bw}, 8'h07);
      u_host.wr(2'h3, 8'h06);
      repeat (3)
      begin
         symbol_tick <= 1'b1;
         @(posedge mclk);
         symbol_tick <= 1'b0;
         @(posedge mclk);
      end
      check({5'h0, bw}, 8'h04);
      repeat (4)
      begin
         symbol_tick <= 1'b1;
         @(posedge mclk);
         symbol_tick <= 1'b0;
         @(posedge mclk);
      end
      check({5'h0, bw}, 8'h02);
      check({5'h0, lrt}, 8'h01);
      check({6'h0, acquire_symbol_timing, acquire_signal_levels}, 8'h00);
      $display("test acquisition done");
      end_of_test();
   end
   // Watchdog well beyond the expected run length
   initial
   begin
      repeat (6000) @(posedge mclk);
      err_count++;
      end_of_test();
   end
endmodule
